// ==== logic/smb_controller.sv ====
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module smb_controller
  import smb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  smb_link_if.ctrl         link
);

  typedef struct packed {
    smb_ctl_st_t       st;
    logic [CNT_W-1:0]  cnt;
    logic              refOne;
    logic              initDone;
    logic [3:0]        pendOp;
    logic [CFG_W-1:0]  cfgReg;
    logic [CFG_W-1:0]  extReg;
    logic [CFG_W-1:0]  liveCfg;
    logic [CA_W-1:0]   addrReg;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [31:0]       prdata;
    logic              csN;
    smb_cmd_t          cmd;
    logic              bankSel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
    logic              dqOe;
  } smb_ctl_state_t;

  localparam smb_ctl_state_t CTL_RST = '{
    st: ST_PWR, cnt: PWR_WAIT_CYC, refOne: 1'b0, initDone: 1'b0, pendOp: 4'h0, cfgReg: CFG_RST,
    extReg: EXTCFG_RST, liveCfg: CFG_RST, addrReg: '0, wdata: '0, rdata: '0, prdata: '0,
    csN: 1'b1, cmd: CMD_NOP, bankSel: 1'b0, addr: '0, dqOut: '0, dqOe: 1'b0};

  smb_ctl_state_t c_q;
  smb_ctl_state_t c_d;
  logic           mapped;
  logic           busy;
  logic [CFG_W-1:0] safeCfg;

  // Reserved codes are replaced before they reach the part, since their effect there is undefined.
  function automatic logic [CFG_W-1:0] cfgSafe(input logic [CFG_W-1:0] raw);
    logic [CFG_W-1:0] v;
    v = raw & 12'h3FF;   // R09
    v[OPM_LSB +: OPM_W] = OPM_STD;   // R14
    if (!(v[BL_LSB +: BL_W] inside {BL_1, BL_2, BL_4, BL_8}) &&
        !((v[BL_LSB +: BL_W] == BL_PAGE) && !v[BT_BIT])) begin
      v[BL_LSB +: BL_W] = BL_1;   // R20
    end
    if (!(v[CL_LSB +: CL_W] inside {CL_1, CL_2, CL_3})) begin
      v[CL_LSB +: CL_W] = CL_3;
    end
    cfgSafe = v;
  endfunction

  assign busy    = (c_q.st != ST_IDLE) || (c_q.pendOp != 4'h0);
  assign safeCfg = cfgSafe(c_q.cfgReg);
  assign mapped  = paddr inside {REG_CFG, REG_EXTCFG, REG_CMD, REG_ADDR, REG_WDATA, REG_STATUS, REG_RDATA};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    c_d      = c_q;
    c_d.cmd  = CMD_NOP;   // R05
    c_d.csN  = 1'b0;
    c_d.dqOe = 1'b0;
    if (c_q.cnt != '0) begin
      c_d.cnt = c_q.cnt - 12'h001;
    end
    if (psel && !penable) begin
      case (paddr)
        REG_CFG:    c_d.prdata = {20'h00000, c_q.cfgReg};
        REG_EXTCFG: c_d.prdata = {20'h00000, c_q.extReg};
        REG_ADDR:   c_d.prdata = {11'h000, c_q.addrReg};
        REG_WDATA:  c_d.prdata = {16'h0000, c_q.wdata};
        REG_STATUS: c_d.prdata = {30'h00000000, busy, c_q.initDone};
        REG_RDATA:  c_d.prdata = {16'h0000, c_q.rdata};
        default:    c_d.prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        REG_CFG:    c_d.cfgReg = pwdata[CFG_W-1:0];
        REG_EXTCFG: c_d.extReg = pwdata[CFG_W-1:0];
        REG_ADDR:   c_d.addrReg = pwdata[CA_W-1:0];
        REG_WDATA:  c_d.wdata = pwdata[DATA_W-1:0];
        REG_CMD: begin
          if (!busy && c_q.initDone) begin
            c_d.pendOp = pwdata[3:0];
          end
        end
        default: c_d.pendOp = c_q.pendOp;
      endcase
    end
    case (c_q.st)
      ST_PWR: begin
        if (c_q.cnt == '0) begin   // R05
          c_d.cmd          = CMD_PRE;   // R06
          c_d.addr[AP_BIT] = 1'b1;
          c_d.cnt          = TRP_CYC;
          c_d.st           = ST_PRE;
        end
      end
      ST_PRE: begin
        if (c_q.cnt == '0) begin
          if (!c_q.initDone) begin
            c_d.cmd = CMD_REF;   // R06
            c_d.cnt = TRC_CYC;
            c_d.st  = ST_REF;
          end else begin
            c_d.st = ST_IDLE;
          end
        end
      end
      ST_REF: begin
        if (c_q.cnt == '0) begin
          if (!c_q.refOne) begin
            c_d.refOne = 1'b1;
            c_d.cmd    = CMD_REF;   // R06
            c_d.cnt    = TRC_CYC;
          end else begin
            c_d.cmd     = CMD_LMR;   // R07
            c_d.bankSel = 1'b0;
            c_d.addr    = safeCfg[ADDR_W-1:0];
            c_d.liveCfg = safeCfg;
            c_d.cnt     = TMRD_CYC;
            c_d.st      = ST_LMR;
          end
        end
      end
      ST_LMR: begin
        if (c_q.cnt == '0) begin   // R08
          c_d.initDone = 1'b1;
          c_d.st       = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (c_q.pendOp[OP_RD] || c_q.pendOp[OP_WR]) begin
          c_d.cmd     = CMD_ACT;   // R03
          c_d.bankSel = c_q.addrReg[AF_BANK];
          c_d.addr    = c_q.addrReg[AF_ROW +: ROW_W];
          c_d.cnt     = TRCD_CYC;
          c_d.st      = ST_ACT;
        end else if (c_q.pendOp[OP_LMR] || c_q.pendOp[OP_EXT]) begin
          c_d.cmd     = CMD_LMR;   // R08
          c_d.bankSel = !c_q.pendOp[OP_LMR];   // R22
          c_d.addr    = c_q.pendOp[OP_LMR] ? safeCfg[ADDR_W-1:0] : c_q.extReg[ADDR_W-1:0];
          c_d.liveCfg = c_q.pendOp[OP_LMR] ? safeCfg : c_q.liveCfg;
          c_d.pendOp  = c_q.pendOp[OP_LMR] ? (c_q.pendOp & 4'hB) : (c_q.pendOp & 4'h7);
          c_d.cnt     = TMRD_CYC;
          c_d.st      = ST_LMR;
        end
      end
      ST_ACT: begin
        if (c_q.cnt == '0) begin
          c_d.addr = {2'h0, c_q.addrReg[COL_W-1:0]};
          if (c_q.pendOp[OP_RD]) begin
            c_d.cmd    = CMD_RD;
            c_d.pendOp = c_q.pendOp & 4'hE;
            c_d.cnt    = CNT_W'(c_q.liveCfg[CL_LSB +: CL_W]) + 12'h001;
            c_d.st     = ST_RDW;
          end else begin
            c_d.cmd    = CMD_WR;
            c_d.dqOut  = c_q.wdata;
            c_d.dqOe   = 1'b1;
            c_d.pendOp = c_q.pendOp & 4'hD;
            c_d.st     = ST_TERM;
          end
        end
      end
      ST_RDW: begin
        if (c_q.cnt == 12'h001) begin   // R21
          c_d.rdata = link.dq;
          c_d.cmd   = CMD_BST;   // R16
          c_d.st    = ST_CLOSE;
        end
      end
      ST_TERM: begin
        c_d.cmd = CMD_BST;   // R16
        c_d.st  = ST_CLOSE;
      end
      ST_CLOSE: begin
        c_d.cmd          = CMD_PRE;
        c_d.addr[AP_BIT] = 1'b1;
        c_d.cnt          = TRP_CYC;
        c_d.st           = ST_PRE;
      end
      default: c_d.st = ST_PWR;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_q <= CTL_RST;
    end else begin
      c_q <= c_d;
    end
  end

  assign prdata       = c_q.prdata;
  assign link.csN     = c_q.csN;
  assign link.rasN    = c_q.cmd[2];
  assign link.casN    = c_q.cmd[1];
  assign link.weN     = c_q.cmd[0];
  assign link.bankSel = c_q.bankSel;
  assign link.addr    = c_q.addr;
  assign link.ctlDq   = c_q.dqOut;
  assign link.ctlDqOe = c_q.dqOe;

endmodule // smb_controller

// ==== logic/smb_pkg.sv ====
package smb_pkg;

  localparam int BANK_CNT  = 2;
  localparam int ROW_CNT   = 2048;
  localparam int COL_CNT   = 512;
  localparam int ROW_W     = 11;
  localparam int COL_W     = 9;
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 11;
  localparam int CFG_W     = 12;
  localparam int CA_W      = 1 + ROW_W + COL_W;
  localparam int MEM_WORDS = BANK_CNT * ROW_CNT * COL_CNT;

  // Configuration word layout.
  localparam int BL_LSB  = 0;
  localparam int BL_W    = 3;
  localparam int BT_BIT  = 3;
  localparam int CL_LSB  = 4;
  localparam int CL_W    = 3;
  localparam int OPM_LSB = 7;
  localparam int OPM_W   = 2;
  localparam int WB_BIT  = 9;
  localparam int AP_BIT  = 10;

  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_1    = 3'h1;
  localparam logic [2:0] CL_2    = 3'h2;
  localparam logic [2:0] CL_3    = 3'h3;
  localparam logic [1:0] OPM_STD = 2'h0;

  localparam logic [COL_W-1:0] MASK_1    = 9'h000;
  localparam logic [COL_W-1:0] MASK_2    = 9'h001;
  localparam logic [COL_W-1:0] MASK_4    = 9'h003;
  localparam logic [COL_W-1:0] MASK_8    = 9'h007;
  localparam logic [COL_W-1:0] MASK_PAGE = 9'h1FF;

  // Command code is {rasN, casN, weN} with the chip selected.
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } smb_cmd_t;

  // Timing.
  localparam int CNT_W         = 12;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_MHZ       = 25;
  localparam int PWR_WAIT_US   = 100;
  localparam int TRP_NS        = 20;
  localparam int TRCD_NS       = 20;
  localparam int TRC_NS        = 80;
  localparam int TMRD_CLKS     = 2;
  localparam int PWR_RAW  = PWR_WAIT_US * CLK_MHZ;
  localparam int TRP_RAW  = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRCD_RAW = (TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRC_RAW  = (TRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] PWR_WAIT_CYC = CNT_W'((PWR_RAW < 1) ? 1 : PWR_RAW);
  localparam logic [CNT_W-1:0] TRP_CYC      = CNT_W'((TRP_RAW < 1) ? 1 : TRP_RAW);
  localparam logic [CNT_W-1:0] TRCD_CYC     = CNT_W'((TRCD_RAW < 1) ? 1 : TRCD_RAW);
  localparam logic [CNT_W-1:0] TRC_CYC      = CNT_W'((TRC_RAW < 1) ? 1 : TRC_RAW);
  localparam logic [CNT_W-1:0] TMRD_CYC     = CNT_W'(TMRD_CLKS);

  // Controller register map, byte addresses.
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_EXTCFG = 8'h04;
  localparam logic [7:0] REG_CMD    = 8'h08;
  localparam logic [7:0] REG_ADDR   = 8'h0C;
  localparam logic [7:0] REG_WDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RDATA  = 8'h18;
  localparam int OP_RD   = 0;
  localparam int OP_WR   = 1;
  localparam int OP_LMR  = 2;
  localparam int OP_EXT  = 3;
  localparam int AF_BANK = 20;
  localparam int AF_ROW  = 9;
  localparam logic [CFG_W-1:0] CFG_RST     = 12'h022;
  localparam logic [CFG_W-1:0] EXTCFG_RST  = 12'h000;
  localparam logic [CFG_W-1:0] DEV_CFG_RST = 12'h000;

  typedef enum logic [8:0] {
    ST_PWR   = 9'h001,
    ST_PRE   = 9'h002,
    ST_REF   = 9'h004,
    ST_LMR   = 9'h008,
    ST_IDLE  = 9'h010,
    ST_ACT   = 9'h020,
    ST_RDW   = 9'h040,
    ST_TERM  = 9'h080,
    ST_CLOSE = 9'h100
  } smb_ctl_st_t;

endpackage

// ==== logic/smb_link_if.sv ====
`timescale 1ns/10ps
interface smb_link_if
  import smb_pkg::*;
();
  logic              csN;
  logic              rasN;
  logic              casN;
  logic              weN;
  logic              bankSel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] ctlDq;
  logic              ctlDqOe;
  logic [DATA_W-1:0] memDq;
  logic              memDqOe;
  logic [DATA_W-1:0] dq;

  // Shared data wire: the controller wins when it drives.
  assign dq = ctlDqOe ? ctlDq : memDq;

  modport ctrl (output csN, rasN, casN, weN, bankSel, addr, ctlDq, ctlDqOe, input dq);
  modport mem  (input csN, rasN, casN, weN, bankSel, addr, dq, output memDq, memDqOe);
endinterface

// ==== logic/smb_sdram_device.sv ====
// Summary of operation
// R01 - Two banks, 2048 rows, 512 columns, 16-bit.
// R02 - All inputs sampled on rising clock edge.
// R03 - Row-open picks bank and row first.
// R04 - Read/write takes start column from address.
// R05 - Controller waits 100 us with no-ops.
// R06 - Controller precharges all, then two refreshes.
// R07 - Config and refreshes precede first row-open.
// R08 - Config loaded while idle, kept until reloaded.
// R09 - Config word fields decoded at fixed bits.
// R10 - Burst codes give 1,2,4,8 or page.
// R11 - Ordering bit selects sequential or interleaved.
// R12 - Latency codes give one to three clocks.
// R13 - Single write bit forces one-word writes.
// R14 - Only mode bits zero allow standard operation.
// R15 - Burst wraps inside aligned length-sized block.
// R16 - Page burst wraps in row, terminate ends.
// R17 - Length one uses start column only.
// R18 - Sequential adds beat modulo burst length.
// R19 - Interleaved XORs start offset with beat.
// R20 - Controller never programs reserved burst codes.
// R21 - Read data valid latency edges after command.
// R22 - Bank select picks base or extended word.
// R23 - Page burst covers all 512 columns.
`timescale 1ns/10ps
module smb_sdram_device
  import smb_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  smb_link_if.mem                link,
  output logic      [CFG_W-1:0]  baseCfgWord,
  output logic      [CFG_W-1:0]  extCfgWord,
  output logic                   standardMode,
  output logic                   burstActive
);

  typedef struct packed {
    logic [BANK_CNT-1:0][ROW_W-1:0] openRow;
    logic [CFG_W-1:0]               baseCfg;
    logic [CFG_W-1:0]               extCfg;
    logic                           burstOn;
    logic                           burstWr;
    logic                           bBank;
    logic [ROW_W-1:0]               bRow;
    logic [COL_W-1:0]               bStart;
    logic [COL_W-1:0]               beat;
    logic [1:0]                     rdWait;
    logic [DATA_W-1:0]              dqOut;
    logic                           dqOe;
  } smb_dev_state_t;

  localparam smb_dev_state_t DEV_RST = '{
    openRow: '0, baseCfg: DEV_CFG_RST, extCfg: DEV_CFG_RST, burstOn: 1'b0, burstWr: 1'b0,
    bBank: 1'b0, bRow: '0, bStart: '0, beat: '0, rdWait: 2'h0, dqOut: '0, dqOe: 1'b0};

  // Array contents are not reset, as in a real part after power-up.
  logic [DATA_W-1:0] mem [MEM_WORDS];   // R01

  smb_dev_state_t   s_q;
  smb_dev_state_t   s_d;
  smb_cmd_t         cmd;
  logic             sel;
  logic             isRd;
  logic             isWr;
  logic             fetch;
  logic             wrStep;
  logic [COL_W-1:0] lastBeat;
  logic [COL_W-1:0] col;
  logic [CA_W-1:0]  memIdx;
  logic             memWe;

  // Block mask; its value is also the index of the last beat.
  function automatic logic [COL_W-1:0] burstMask(input logic [CFG_W-1:0] cfg);
    case (cfg[BL_LSB +: BL_W])   // R10
      BL_1:    burstMask = MASK_1;
      BL_2:    burstMask = MASK_2;
      BL_4:    burstMask = MASK_4;
      BL_8:    burstMask = MASK_8;
      BL_PAGE: burstMask = cfg[BT_BIT] ? MASK_1 : MASK_PAGE;   // R23
      default: burstMask = MASK_1;
    endcase
  endfunction

  // Upper bits hold the block; the low bits walk inside it, so a length of one is the start itself.
  function automatic logic [COL_W-1:0] colOf(input logic [COL_W-1:0] start,
                                             input logic [COL_W-1:0] beat,
                                             input logic [CFG_W-1:0] cfg);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] walk;
    mask = burstMask(cfg);
    if (cfg[BT_BIT]) begin   // R11
      walk = start ^ beat;   // R19
    end else begin
      walk = start + beat;   // R18
    end
    colOf = (start & ~mask) | (walk & mask);   // R15 R16 R17
  endfunction

  // Stored value is latency minus one.
  function automatic logic [1:0] rdDelay(input logic [CFG_W-1:0] cfg);
    case (cfg[CL_LSB +: CL_W])   // R12
      CL_1:    rdDelay = 2'h0;
      CL_2:    rdDelay = 2'h1;
      CL_3:    rdDelay = 2'h2;
      default: rdDelay = 2'h2;
    endcase
  endfunction

  assign standardMode = (s_q.baseCfg[OPM_LSB +: OPM_W] == OPM_STD);   // R14

  always_comb begin
    s_d      = s_q;
    s_d.dqOe = 1'b0;
    cmd      = smb_cmd_t'({link.rasN, link.casN, link.weN});
    sel      = !link.csN;
    // Reserved modes refuse bursts; the part does nothing defined there anyway.
    isRd     = sel && (cmd == CMD_RD) && standardMode;
    isWr     = sel && (cmd == CMD_WR) && standardMode;
    if (sel && ((cmd == CMD_RD) || (cmd == CMD_WR) || (cmd == CMD_BST) || (cmd == CMD_PRE))) begin
      s_d.burstOn = 1'b0;   // R16
    end
    if (sel && (cmd == CMD_ACT)) begin
      s_d.openRow[link.bankSel] = link.addr[ROW_W-1:0];   // R03
    end
    if (sel && (cmd == CMD_LMR)) begin
      if (link.bankSel) begin   // R22
        s_d.extCfg = {1'b1, link.addr};
      end else begin
        s_d.baseCfg = {1'b0, link.addr};   // R08 R09
      end
    end
    if (!isRd && s_q.burstOn && !s_q.burstWr && (s_q.rdWait != 2'h0)) begin
      s_d.rdWait = s_q.rdWait - 2'h1;   // R21
    end
    if (isRd || isWr) begin
      s_d.burstOn = 1'b1;
      s_d.burstWr = isWr;
      s_d.bBank   = link.bankSel;
      s_d.bRow    = s_q.openRow[link.bankSel];   // R03
      s_d.bStart  = link.addr[COL_W-1:0];   // R04
      s_d.beat    = '0;
      s_d.rdWait  = rdDelay(s_q.baseCfg);   // R21
    end
    fetch    = s_d.burstOn && !s_d.burstWr && (s_d.rdWait == 2'h0);   // R21
    wrStep   = s_d.burstOn && s_d.burstWr;
    lastBeat = (s_d.burstWr && s_q.baseCfg[WB_BIT]) ? MASK_1 : burstMask(s_q.baseCfg);   // R13
    col      = colOf(s_d.bStart, s_d.beat, s_q.baseCfg);
    memIdx   = {s_d.bBank, s_d.bRow, col};
    memWe    = wrStep;
    if (fetch) begin
      s_d.dqOut = mem[memIdx];
      s_d.dqOe  = 1'b1;
    end
    if (fetch || wrStep) begin
      if (s_d.beat == lastBeat) begin
        s_d.burstOn = 1'b0;
      end
      s_d.beat = s_d.beat + 9'h001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin   // R02
    if (!rst_n) begin
      s_q <= DEV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (memWe) begin
      mem[memIdx] <= link.dq;
    end
  end

  assign link.memDq   = s_q.dqOut;
  assign link.memDqOe = s_q.dqOe;
  assign baseCfgWord  = s_q.baseCfg;
  assign extCfgWord   = s_q.extCfg;
  assign burstActive  = s_q.burstOn;

endmodule // smb_sdram_device

// ==== tb/smb_link_checker.sv ====
`timescale 1ns/10ps
module smb_link_checker
  import smb_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              csN,
  input wire logic              rasN,
  input wire logic              casN,
  input wire logic              weN,
  input wire logic              bankSel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] ctlDq,
  input wire logic              ctlDqOe,
  input wire logic [DATA_W-1:0] memDq,
  input wire logic              memDqOe,
  input wire logic [DATA_W-1:0] dq
);
  logic [2:0]       cmd;
  logic             isCmd;
  logic [1:0]       lat;
  logic [CNT_W-1:0] pwrCnt_q;
  logic [1:0]       refCnt_q;
  logic             cfgDone_q;
  logic             seenCmd_q;
  logic             rowOpen_q;
  logic [CFG_W-1:0] cfg_q;

  assign cmd   = {rasN, casN, weN};
  assign isCmd = !csN && cmd != CMD_NOP;
  // The checker mirrors the device's latency decode, reserved codes read as three.
  assign lat   = (cfg_q[6:4] == CL_1) ? 2'h1 : (cfg_q[6:4] == CL_2) ? 2'h2 : 2'h3;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrCnt_q  <= '0;
      refCnt_q  <= 2'h0;
      cfgDone_q <= 1'b0;
      seenCmd_q <= 1'b0;
      rowOpen_q <= 1'b0;
      cfg_q     <= '0;
    end else begin
      if (pwrCnt_q != PWR_WAIT_CYC) pwrCnt_q <= pwrCnt_q + 1'b1;
      if (isCmd) seenCmd_q <= 1'b1;
      if (isCmd && cmd == CMD_REF && refCnt_q != 2'h2) refCnt_q <= refCnt_q + 2'h1;
      if (isCmd && cmd == CMD_LMR && !bankSel) begin
        cfgDone_q <= 1'b1;
        cfg_q     <= {1'b0, addr};
      end
      if (isCmd && cmd == CMD_ACT) rowOpen_q <= 1'b1;
      else if (isCmd && cmd == CMD_PRE && addr[10]) rowOpen_q <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence sRead;
    isCmd && cmd == CMD_RD && cfg_q[8:7] == OPM_STD;
  endsequence
  sequence sQuiet;
    csN || cmd == CMD_NOP;
  endsequence
  sequence sLoadBase;
    isCmd && cmd == CMD_LMR && !bankSel;
  endsequence

  a_read_lat_one: assert property (sRead ##0 lat == 2'h1 |-> ##1 memDqOe)
    else $error("read data late at latency one");
  a_read_lat_two: assert property (sRead ##0 lat == 2'h2 |-> ##1 !memDqOe ##1 memDqOe)
    else $error("read data timing wrong at latency two");
  a_read_lat_three: assert property (sRead ##0 lat == 2'h3 |-> ##1 !memDqOe [*2] ##1 memDqOe)
    else $error("read data timing wrong at latency three");
  a_power_wait: assert property (isCmd |-> pwrCnt_q == PWR_WAIT_CYC)
    else $error("command issued during power-up wait");
  a_first_precharge: assert property (isCmd && !seenCmd_q |-> cmd == CMD_PRE && addr[10])
    else $error("first command is not precharge all");
  a_open_after_init: assert property (isCmd && cmd == CMD_ACT |-> refCnt_q == 2'h2 && cfgDone_q)
    else $error("row opened before init done");
  a_config_idle_wait: assert property (isCmd && cmd == CMD_LMR |-> !rowOpen_q ##1 sQuiet [*2])
    else $error("config load while busy or too soon");
  a_config_fields: assert property (sLoadBase |-> !addr[10] && addr[8:7] == OPM_STD)
    else $error("config word reserved bits set");
  a_burst_code_legal: assert property (sLoadBase |-> (addr[2:0] <= BL_8 || addr[2:0] == BL_PAGE && !addr[3])
    && addr[6:4] != 3'h0 && addr[6:4] <= CL_3)
    else $error("reserved burst or latency code loaded");
  a_open_then_access: assert property (isCmd && cmd == CMD_ACT |=> !(isCmd && (cmd == CMD_RD || cmd == CMD_WR)))
    else $error("access too soon after row open");
  a_read_needs_row: assert property (sRead |-> rowOpen_q)
    else $error("read without open row");
  a_write_drives_bus: assert property (isCmd && cmd == CMD_WR |-> ctlDqOe && dq == ctlDq)
    else $error("write data not on bus");
  a_single_beat: assert property ($rose(memDqOe) && cfg_q[2:0] == BL_1 |=> !memDqOe)
    else $error("length one read gave extra beat");
endmodule // smb_link_checker

// ==== tb/sdram_mode_and_burst_logic_test.sv ====
`timescale 1ns/10ps
module sdram_mode_and_burst_logic_test;
  import smb_pkg::*;
  logic             core_clk;
  logic             rst_n;
  logic [7:0]       paddr;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [CFG_W-1:0] baseCfgWord;
  logic [CFG_W-1:0] extCfgWord;
  logic             standardMode;
  logic             burstActive;
  logic [31:0]      rdv;
  logic             erv;
  logic [11:0]      cfg;
  logic [11:0]      ext;
  logic [11:0]      expCfg;
  logic             bank;
  logic [10:0]      row;
  logic [8:0]       start;
  logic [8:0]       col;
  logic [15:0]      beats[$];
  int               err_total;
  int               checks;
  int               cycles;
  int               seed;
  int               n;
  logic [11:0]      corner[4] = '{12'h033, 12'h03B, 12'h017, 12'h186};

  smb_link_if link();
  smb_controller smb_controller_inst(.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  smb_sdram_device smb_sdram_device_inst(.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .baseCfgWord(baseCfgWord), .extCfgWord(extCfgWord), .standardMode(standardMode),
    .burstActive(burstActive));
  smb_link_checker smb_link_checker_inst(.core_clk(core_clk), .rst_n(rst_n), .csN(link.csN),
    .rasN(link.rasN), .casN(link.casN), .weN(link.weN), .bankSel(link.bankSel), .addr(link.addr),
    .ctlDq(link.ctlDq), .ctlDqOe(link.ctlDqOe), .memDq(link.memDq), .memDqOe(link.memDqOe), .dq(link.dq));

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // Read beats are taken from the wire, since the controller keeps only the first one.
  always @(posedge core_clk) begin
    cycles++;
    if (link.memDqOe === 1'b1) beats.push_back(link.memDq);
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  task results;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task doCmd(input logic [3:0] c);
    apb(1'b1, REG_CMD, {28'h0000000, c});
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
    end while (rdv[1] !== 1'b0);
  endtask

  task access(input logic b, input logic [8:0] c, input logic [15:0] v, input logic [3:0] op);
    apb(1'b1, REG_ADDR, 32'({b, row, c}));
    apb(1'b1, REG_WDATA, {16'h0000, v});
    doCmd(op);
  endtask

  function automatic logic [15:0] pat(input int it, input logic [8:0] c);
    return {7'(it), c};
  endfunction

  // Reserved codes are folded by the controller, so the device only ever sees legal ones.
  function automatic logic [11:0] sanit(input logic [11:0] c);
    logic [11:0] s;
    s = c;
    s[11:10] = 2'h0;
    s[8:7] = OPM_STD;
    if (s[2:0] > BL_8 && s[2:0] != BL_PAGE) s[2:0] = BL_1;
    if (s[6:4] == 3'h0 || s[6:4] > CL_3) s[6:4] = CL_3;
    return s;
  endfunction

  function automatic logic [8:0] nextCol(input logic [8:0] s, input logic [11:0] c);
    logic [8:0] m;
    m = (c[2:0] == BL_PAGE) ? MASK_PAGE : (c[2:0] == BL_8) ? MASK_8 : (c[2:0] == BL_4) ? MASK_4 : MASK_2;
    return c[BT_BIT] ? (s ^ 9'h001) : ((s & ~m) | ((s + 9'h001) & m));
  endfunction

  initial begin
    seed = 54;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    row = 11'h000;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, REG_CFG, 32'h0);
    chk("cfg reset", 32'h00000022, rdv);
    apb(1'b0, REG_EXTCFG, 32'h0);
    chk("extcfg reset", 32'h0, rdv);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, erv});
    chk("unmapped data", 32'h0, rdv);
    apb(1'b1, REG_CMD, 32'h1);
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rdv[0] !== 1'b1 && n < 1500);
    chk("init done", 32'h1, {31'h0, rdv[0]});
    chk("early cmd", 32'h0, {31'h0, rdv[1]});
    chk("boot word", {20'h0, sanit(12'h022)}, {20'h0, baseCfgWord});
    for (int it = 0; it < 12; it++) begin
      cfg = (it < 4) ? corner[it] : 12'($random(seed));
      if (cfg[2:0] == BL_PAGE) cfg[BT_BIT] = 1'b0;
      ext = 12'($random(seed));
      apb(1'b1, REG_CFG, {20'h0, cfg});
      apb(1'b1, REG_EXTCFG, {20'h0, ext});
      doCmd(4'h4);
      doCmd(4'h8);
      expCfg = sanit(cfg);
      chk("base word", {20'h0, expCfg}, {20'h0, baseCfgWord});
      chk("ext word", {20'h0, 1'b1, ext[10:0]}, {20'h0, extCfgWord});
      chk("standard mode", 32'h1, {31'h0, standardMode});
      bank = 1'($random(seed));
      row = 11'($random(seed));
      start = 9'($random(seed));
      access(~bank, start, ~pat(it, start), 4'h2);
      for (int k = 0; k < 9; k++) begin
        col = (k < 8) ? {start[8:3], 3'(k)} : start + 9'h001;
        access(bank, col, pat(it, col), 4'h2);
      end
      beats.delete();
      access(bank, start, 16'h0000, 4'h1);
      apb(1'b0, REG_RDATA, 32'h0);
      chk("read data", {16'h0, pat(it, start)}, rdv);
      chk("burst ended", 32'h0, {31'h0, burstActive});
      n = (expCfg[2:0] == BL_1) ? 1 : 2;
      chk("beat count", n, beats.size());
      if (n == 2 && beats.size() == 2) chk("second beat", {16'h0, pat(it, nextCol(start, expCfg))}, {16'h0, beats[1]});
      access(~bank, start, 16'h0000, 4'h1);
      apb(1'b0, REG_RDATA, 32'h0);
      chk("other bank", {16'h0, ~pat(it, start)}, rdv);
    end
    results();
  end
endmodule // sdram_mode_and_burst_logic_test
